// ===== rtl/vfd_display_control_regs.sv
// display-control register bank: shutdown, font pointer, cursor, annunciators
// Contract
// R1 - config bit 0: 0 shutdown, 1 normal operation
// R2 - writes accepted in shutdown; display test overrides shutdown
// R3 - scan stops after current mux period, then blanking disables driver
// R4 - shutdown entry and exit leave all stored data untouched
// R5 - pump square wave held low in shutdown, resumes afterwards
// R6 - filament phase outputs held low in shutdown, restored afterwards
// R7 - blank whole first mux cycle after shutdown exit
// R8 - glyph byte 0 drives a..g, byte 1 g2..m, ignored for 7-segment
// R9 - writing 0x80 to 0x05 sets pointer zero; also reset value
// R10 - writing 0xAF sets pointer to highest entry 47
// R11 - pointer writes 0xB0 to 0xFF reset pointer to zero
// R12 - pointer read gives top bit 0 and the address below
// R13 - cursor bit 7 selects blinking: lit first half only
// R14 - cursor bit 6 row, low bits digit; bits 6 and 5 set hide cursor
// R15 - annunciator byte holds four two-bit fields, A1 in low bits
// R16 - field: 00 off, 01 first half, 10 second half, 11 on
// R17 - config bits 7..0: phase, mode, clear, sync, font, rate, lock, shutdown
// R18 - each font data access advances pointer by one afterwards; code holds the pointer at entry 47 and ignores further data
// R19 - blink rate bit: 0 slow 1 s halves, 1 fast 0.5 s halves
// R20 - config read returns live blink phase in top bit
`timescale 1ns/10ps
`include "vfd_ctl_consts.svh"

module vfd_display_control_regs
   import vfd_ctl_pkg::*;
#(
   parameter int unsigned BLINK_SLOW = `BLINK_SLOW_CYC,
   parameter int unsigned BLINK_FAST = `BLINK_FAST_CYC
)(
   input  wire logic          core_clk_i,
   input  wire logic          arst_n_i,
   input  wire logic          clk_en_i,
   input  wire reg_req_type   req_i,
   input  wire logic          display_test_i,
   input  wire logic          pump_clock_mode_i,
   input  wire logic          pump_wave_i,
   input  wire logic          filament_mode_a_i,
   input  wire logic          filament_mode_b_i,
   input  wire logic          filament_wave_a_i,
   input  wire logic          filament_wave_b_i,
   input  wire logic [5:0]    glyph_sel_i,
   input  wire logic [1:0]    seg_type_i,
   output logic [7:0]         rdata_o,
   output drive_out_type      drive_o,
   output logic               mux_clock_o,
   output logic               mux_cycle_end_o,
   output glyph_type          glyph_o,
   output logic [7:0]         cursor_o,
   output logic               cursor_lit_o,
   output logic [3:0]         annun_lit_o,
   output logic [7:0]         config_o,
   output logic               blink_phase_o
);

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic       rst_meta;
   logic       rst_n;

   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ------------------------------------------------------------
   // register decode
   // ------------------------------------------------------------
   logic       wr_cfg;
   logic       wr_cur;
   logic       wr_ann;
   logic       acc_font;
   logic       font_ptr_wr;
   logic [7:0] cfg;
   logic [7:0] cursor;
   logic [7:0] annun;
   logic [5:0] font_ptr;
   logic       font_done;
   logic       blink_phase;
   logic [6:0] font_ram [0:`FONT_ENTRIES-1];

   // writes land in any scan state, shutdown included [R2] [R4]
   assign wr_cfg      = clk_en_i && req_i.wr && (req_i.addr == `ADDR_CONFIG);
   assign wr_cur      = clk_en_i && req_i.wr && (req_i.addr == `ADDR_CURSOR);
   assign wr_ann      = clk_en_i && req_i.wr && (req_i.addr == `ADDR_ANNUN);
   assign font_ptr_wr = clk_en_i && req_i.wr && (req_i.addr == `ADDR_FONT)
                        && req_i.wdata[`FONT_SET_FLAG];
   assign acc_font    = clk_en_i && (req_i.addr == `ADDR_FONT)
                        && ((req_i.wr && !req_i.wdata[`FONT_SET_FLAG]) || req_i.rd);

   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         cfg <= `CFG_RESET;
      else if (wr_cfg)
         cfg <= req_i.wdata;   // [R17]
   end

   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         cursor <= `CUR_RESET;
      else if (wr_cur)
         cursor <= req_i.wdata;
   end

   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         annun <= `ANN_RESET;
      else if (wr_ann)
         annun <= req_i.wdata;
   end

   // ------------------------------------------------------------
   // font pointer and glyph memory
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         font_ptr  <= `FONT_PTR_ZERO;   // [R9]
         font_done <= 1'b0;
      end
      else if (font_ptr_wr)
      begin
         // out-of-range set values fold back to entry zero [R11]
         if (req_i.wdata > `FONT_LAST_SET)
            font_ptr <= `FONT_PTR_ZERO;
         else
            font_ptr <= req_i.wdata[5:0];   // [R9] [R10]
         font_done <= 1'b0;
      end
      else if (acc_font && !font_done)
      begin
         // last entry sticks; further data is ignored [R18]
         if (font_ptr == `FONT_PTR_MAX)
            font_done <= 1'b1;
         else
            font_ptr <= font_ptr + 6'h01;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (acc_font && req_i.wr && !font_done)
         font_ram[font_ptr] <= req_i.wdata[6:0];
   end

   logic [5:0] glyph_base;
   assign glyph_base = {glyph_sel_i[4:0], 1'b0};
   // byte 1 blanked on 7-segment digits [R8]
   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         glyph_o <= '0;
      else if (clk_en_i)
      begin
         glyph_o.seg_lo <= font_ram[glyph_base];
         glyph_o.seg_hi <= (seg_type_i == 2'b00) ? 7'h00 : font_ram[glyph_base + 6'h01];
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         rdata_o <= 8'h00;
      else if (clk_en_i && req_i.rd)
      begin
         case (req_i.addr)
            `ADDR_CONFIG: rdata_o <= {blink_phase, cfg[6:0]};   // [R20]
            `ADDR_FONT:   rdata_o <= {2'b00, font_ptr};          // [R12]
            `ADDR_CURSOR: rdata_o <= cursor;
            `ADDR_ANNUN:  rdata_o <= annun;
            default:      rdata_o <= 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // multiplex timing and shutdown sequencing
   // ------------------------------------------------------------
   localparam int unsigned MUX_LEN = `MUX_CYCLES;
   logic [$clog2(MUX_LEN)-1:0] mux_cnt;
   logic [3:0]                 digit_cnt;
   logic                       period_end;
   logic                       cycle_end;
   logic                       want_sd;
   scan_state_type             state;
   scan_state_type             next_state;

   // display test keeps the scan running even with shutdown set [R1] [R2]
   assign want_sd    = !cfg[`CFG_SHUTDOWN] && !display_test_i;
   assign period_end = (mux_cnt == ($clog2(MUX_LEN))'(MUX_LEN - 1));
   assign cycle_end  = period_end && (digit_cnt == 4'(`MUX_DIGITS - 1));

   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mux_cnt   <= '0;
         digit_cnt <= 4'h0;
      end
      else if (clk_en_i && state != HALT_ST)
      begin
         mux_cnt <= period_end ? '0 : mux_cnt + 1'b1;
         if (period_end)
            digit_cnt <= digit_cnt + 4'h1;
      end
      else if (clk_en_i)
         digit_cnt <= 4'h0;   // a flush out of halt then spans one whole cycle [R7]
   end

   always_comb
   begin
      next_state = state;
      case (state)
         RUN_ST:   if (want_sd) next_state = DRAIN_ST;
         DRAIN_ST: if (period_end) next_state = HALT_ST;      // [R3]
         HALT_ST:  if (!want_sd) next_state = FLUSH_ST;
         FLUSH_ST: if (want_sd ? period_end : cycle_end)
                      next_state = want_sd ? HALT_ST : RUN_ST;   // [R3] [R7]
         default:  next_state = RUN_ST;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         state <= HALT_ST;
      else if (clk_en_i)
         state <= next_state;
   end

   logic halted;
   assign halted = (state == HALT_ST);
   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         drive_o <= '{tube_blank_out: 1'b1, default: 1'b0};
      else if (clk_en_i)
      begin
         drive_o.tube_blank_out   <= (next_state == HALT_ST)
                                     || (next_state == FLUSH_ST);   // [R3] [R7]
         drive_o.pump             <= pump_clock_mode_i ?
                                     (pump_wave_i && !halted) : pump_wave_i;   // [R5]
         drive_o.filament_drive_a <= filament_mode_a_i ?
                                     (filament_wave_a_i && !halted) : filament_wave_a_i;   // [R6]
         drive_o.filament_drive_b <= filament_mode_b_i ?
                                     (filament_wave_b_i && !halted) : filament_wave_b_i;   // [R6]
      end
   end

   assign mux_clock_o     = !halted;
   assign mux_cycle_end_o = cycle_end && !halted;

   // ------------------------------------------------------------
   // blink timing, cursor and annunciators
   // ------------------------------------------------------------
   logic [31:0] blink_cnt;
   logic [31:0] blink_half;
   assign blink_half = cfg[`CFG_RATE] ? BLINK_FAST : BLINK_SLOW;   // [R19]

   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         blink_cnt   <= 32'h0;
         blink_phase <= 1'b0;
      end
      else if (clk_en_i && !halted)
      begin
         if (cfg[`CFG_SYNC] && cycle_end)
         begin
            blink_cnt   <= 32'h0;
            blink_phase <= 1'b0;
         end
         else if (blink_cnt >= blink_half - 32'h1)
         begin
            blink_cnt   <= 32'h0;
            blink_phase <= !blink_phase;
         end
         else
            blink_cnt <= blink_cnt + 32'h1;
      end
   end

   // phase 0 is the first half of the blink period
   assign cursor_lit_o = !(cursor[`CUR_NONE_HI] && cursor[`CUR_NONE_LO])   // [R14]
                         && (!cursor[`CUR_BLINK] || !blink_phase);         // [R13]
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_annun
         logic [1:0] fld;
         assign fld = annun[2*g +: 2];   // [R15]
         assign annun_lit_o[g] = fld[1] && fld[0]
                                 || (fld == 2'b01 && !blink_phase)
                                 || (fld == 2'b10 && blink_phase);   // [R16]
      end
   endgenerate

   assign cursor_o      = cursor;
   assign config_o      = cfg;
   assign blink_phase_o = blink_phase;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb_chk @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n);
   property p_halt_blank;
      halted |-> drive_o.tube_blank_out;
   endproperty
   a_halt_blank: assert property (p_halt_blank) else $error("blank low in halt"); // [R3]
   property p_pump_low;
      clk_en_i && halted && pump_clock_mode_i |=> !drive_o.pump;
   endproperty
   a_pump_low: assert property (p_pump_low) else $error("pump runs in shutdown"); // [R5]
   property p_fil_low;
      clk_en_i && halted && filament_mode_a_i |=> !drive_o.filament_drive_a;
   endproperty
   a_fil_low: assert property (p_fil_low) else $error("filament runs in shutdown"); // [R6]
   property p_flush;
      state == FLUSH_ST |-> drive_o.tube_blank_out;
   endproperty
   a_flush: assert property (p_flush) else $error("flush cycle not blanked"); // [R7]
   property p_ptr_bad;
      font_ptr_wr && req_i.wdata > `FONT_LAST_SET |=> font_ptr == `FONT_PTR_ZERO;
   endproperty
   a_ptr_bad: assert property (p_ptr_bad) else $error("bad pointer kept"); // [R11]
   property p_ptr_max;
      font_ptr_wr && req_i.wdata == `FONT_LAST_SET |=> font_ptr == `FONT_PTR_MAX;
   endproperty
   a_ptr_max: assert property (p_ptr_max) else $error("max pointer wrong"); // [R10]
   property p_ptr_inc;
      acc_font && !font_done && font_ptr < `FONT_PTR_MAX && !font_ptr_wr
      |=> font_ptr == $past(font_ptr) + 6'h01;
   endproperty
   a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not advanced"); // [R18]
   property p_no_cursor;
      cursor[`CUR_NONE_HI] && cursor[`CUR_NONE_LO] |-> !cursor_lit_o;
   endproperty
   a_no_cursor: assert property (p_no_cursor) else $error("hidden cursor lit"); // [R14]
   property p_test_run;
      clk_en_i && display_test_i && state == RUN_ST |=> state == RUN_ST;
   endproperty
   a_test_run: assert property (p_test_run) else $error("test mode stopped scan"); // [R2]
   c_shutdown: cover property (state == DRAIN_ST ##1 state == HALT_ST);
   c_flush:    cover property (state == FLUSH_ST ##1 state == RUN_ST);
   c_ptr_end:  cover property (font_done);

endmodule

// ===== rtl/vfd_ctl_consts.svh
// constants for the display-control register bank
`ifndef VFD_CTL_CONSTS_SVH
`define VFD_CTL_CONSTS_SVH

`define ADDR_FONT        8'h05
`define ADDR_CURSOR      8'h0F
`define ADDR_ANNUN       8'h10
`define ADDR_CONFIG      8'h04
`define CFG_SHUTDOWN     0
`define CFG_LOCK         1
`define CFG_RATE         2
`define CFG_FONT         3
`define CFG_SYNC         4
`define CFG_CLEAR        5
`define CFG_MODE         6
`define CFG_PHASE        7
`define CFG_RESET        8'h00
`define CUR_RESET        8'h60
`define ANN_RESET        8'h00
`define FONT_PTR_MAX     6'h2F
`define FONT_PTR_ZERO    6'h00
`define FONT_SET_FLAG    7
`define FONT_LAST_SET    8'hAF
`define CUR_BLINK        7
`define CUR_ROW          6
`define CUR_NONE_HI      6
`define CUR_NONE_LO      5
`define FONT_ENTRIES     48
`define MUX_PERIOD_NS    100000
`define CLK_PERIOD_NS    100
`define MUX_CYCLES       (`MUX_PERIOD_NS / `CLK_PERIOD_NS)
`define MUX_DIGITS       16
`define BLINK_SLOW_NS    1000000000
`define BLINK_FAST_NS    500000000
`define BLINK_SLOW_CYC   (`BLINK_SLOW_NS / `CLK_PERIOD_NS)
`define BLINK_FAST_CYC   (`BLINK_FAST_NS / `CLK_PERIOD_NS)

`endif

// ===== rtl/vfd_ctl_pkg.sv
// types for the display-control register bank
package vfd_ctl_pkg;

   typedef enum logic [1:0] {
      RUN_ST,
      DRAIN_ST,
      HALT_ST,
      FLUSH_ST
   } scan_state_type;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_type;

   typedef struct packed {
      logic       tube_blank_out;
      logic       pump;
      logic       filament_drive_a;
      logic       filament_drive_b;
   } drive_out_type;

   typedef struct packed {
      logic [6:0] seg_lo;
      logic [6:0] seg_hi;
   } glyph_type;

endpackage

// ===== test/tube_driver_model.sv
// tube driver model: raw drive waveforms and stale-data watch
`timescale 1ns/10ps
module tube_driver_model (
   input  wire logic clk_i,
   input  wire logic arst_n_i,
   input  wire logic blank_i,
   input  wire logic scan_i,
   input  wire logic cyc_end_i,
   input  wire logic test_i,
   output logic      pump_wave_o,
   output logic      fil_a_o,
   output logic      fil_b_o,
   output logic      stale_shown_o
);
   logic [2:0] cnt;
   logic       stale;

   assign pump_wave_o = cnt[1];
   assign fil_a_o     = cnt[2];
   assign fil_b_o     = ~cnt[2];

   // --------------------------------------------
   // shift contents go bad whenever the scan halts
   // --------------------------------------------
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         cnt <= 3'h0;
         stale <= 1'b1;
         stale_shown_o <= 1'b0;
      end
      else
      begin
         cnt <= cnt + 3'h1;
         if (!scan_i)
            stale <= 1'b1;
         else if (cyc_end_i && blank_i)
            stale <= 1'b0;
         // display test reloads every segment, so it is exempt
         if (stale && !blank_i && !test_i)
            stale_shown_o <= 1'b1;
      end
   end
endmodule

// ===== test/vfd_display_control_regs_tb.sv
// testbench for the display-control register bank
`timescale 1ns/10ps
`include "vfd_ctl_consts.svh"
module vfd_display_control_regs_tb import vfd_ctl_pkg::*;;
   logic          core_clk = 1'b0;
   logic          arst_n   = 1'b0;
   reg_req_type   req      = '0;
   logic          dtest    = 1'b0;
   logic          pmode    = 1'b1;
   logic [5:0]    gsel     = 6'h00;
   logic [1:0]    stype    = 2'h1;
   logic          pw, fa, fb, stale, mclk, mend, clit, bph, ph;
   logic [7:0]    rdata, cursor, cfgo, v;
   logic [3:0]    alit;
   drive_out_type drv;
   glyph_type     glyph;
   int            n_errors = 0;
   int            compares = 0;
   int            cyc      = 0;
   int            n, hi, tg;
   logic [7:0]    bad [3] = '{8'hB0, 8'hC3, 8'hFF};
   logic [7:0]    pat [2] = '{8'hE4, 8'h1B};
   logic [7:0]    cv [5]  = '{8'h00, 8'h60, 8'hE5, 8'h80, 8'h5F};
   logic [1:0]    ce [5]  = '{2'h1, 2'h0, 2'h0, 2'h2, 2'h1};

   always #50 core_clk = ~core_clk;

   vfd_display_control_regs #(.BLINK_SLOW(50), .BLINK_FAST(25)) u_vfd_display_control_regs (
      .core_clk_i(core_clk), .arst_n_i(arst_n), .clk_en_i(1'b1), .req_i(req),
      .display_test_i(dtest), .pump_clock_mode_i(pmode), .pump_wave_i(pw),
      .filament_mode_a_i(1'b1), .filament_mode_b_i(1'b1),
      .filament_wave_a_i(fa), .filament_wave_b_i(fb), .glyph_sel_i(gsel),
      .seg_type_i(stype), .rdata_o(rdata), .drive_o(drv), .mux_clock_o(mclk),
      .mux_cycle_end_o(mend), .glyph_o(glyph), .cursor_o(cursor),
      .cursor_lit_o(clit), .annun_lit_o(alit), .config_o(cfgo), .blink_phase_o(bph));

   tube_driver_model u_tube_driver_model (
      .clk_i(core_clk), .arst_n_i(arst_n), .blank_i(drv.tube_blank_out),
      .scan_i(mclk), .cyc_end_i(mend), .test_i(dtest), .pump_wave_o(pw),
      .fil_a_o(fa), .fil_b_o(fb), .stale_shown_o(stale));

   // --------------------------------------------
   // tasks
   // --------------------------------------------
   task test_done;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task chk(input string s, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e)
      begin
         $display("CHECK FAILED %s exp %h got %h", s, e, g);
         n_errors++;
      end
   endtask

   task idle(input int c);
      repeat (c) @(negedge core_clk);
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge core_clk);
      req = '0;
   endtask

   // phase is sampled where the read edge sees it
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      ph = bph;
      @(negedge core_clk);
      req = '0;
      d = rdata;
   endtask

   task wait_blank(input logic lvl, input int lim, output int c);
      c = 0;
      while (drv.tube_blank_out !== lvl && c < lim)
      begin
         @(negedge core_clk);
         c++;
      end
   endtask

   task half(output int c);
      logic p;
      repeat (2)
      begin
         c = 0;
         p = bph;
         while (bph === p && c < 200)
         begin
            @(negedge core_clk);
            c++;
         end
      end
   endtask

   task watch(input int c, output int t, output int h);
      logic p;
      t = 0;
      h = 0;
      p = drv.pump;
      repeat (c)
      begin
         @(negedge core_clk);
         if (drv.pump !== p)
            t++;
         if (drv.filament_drive_a !== 1'b0 || drv.filament_drive_b !== 1'b0)
            h++;
         p = drv.pump;
      end
   endtask

   // flush must cover at least one full mux cycle
   task leave_sd(input logic [7:0] c);
      wr(`ADDR_CONFIG, c);
      wait_blank(1'b0, 40000, n);
      chk("flush", 16'h1, {15'h0, n + 1 >= `MUX_CYCLES * `MUX_DIGITS && n < 40000});
   endtask

   function automatic logic [3:0] ann(input logic [7:0] p, input logic f);
      logic [3:0] r;
      for (int i = 0; i < 4; i++)
         r[i] = (p[2*i+:2] == 2'h3) || (p[2*i+:2] == {f, ~f});
      return r;
   endfunction

   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         n_errors++;
         test_done;
      end
   end

   // --------------------------------------------
   // tests
   // --------------------------------------------
   initial
   begin
      idle(10);
      arst_n = 1'b1;
      idle(3);
      rd(`ADDR_CONFIG, v);
      chk("cfg_rst", {8'h00, ph, 7'h00}, {8'h00, v});
      chk("cur_rst", {8'h00, `CUR_RESET}, {8'h00, cursor});
      chk("blank_rst", 16'h1, {15'h0, drv.tube_blank_out});
      rd(`ADDR_FONT, v);
      chk("ptr_rst", 16'h0, {8'h00, v});
      $display("test reset done");
      wr(`ADDR_FONT, 8'h80);
      wr(`ADDR_FONT, 8'h7E);
      wr(`ADDR_FONT, 8'h55);
      rd(`ADDR_FONT, v);
      chk("ptr_inc", 16'h2, {8'h00, v});
      idle(2);
      chk("glyph14", {2'h0, 7'h7E, 7'h55}, {2'h0, glyph});
      stype = 2'h0;
      idle(2);
      chk("glyph7", {2'h0, 7'h7E, 7'h00}, {2'h0, glyph});
      wr(`ADDR_FONT, 8'hAF);
      rd(`ADDR_FONT, v);
      chk("ptr_max", 16'h2F, {8'h00, v});
      foreach (bad[i])
      begin
         wr(`ADDR_FONT, 8'hAF);
         wr(`ADDR_FONT, bad[i]);
         rd(`ADDR_FONT, v);
         chk("ptr_bad", 16'h0, {8'h00, v});
      end
      $display("test font done");
      leave_sd(8'h01);
      for (int r = 0; r < 2; r++)
      begin
         wr(`ADDR_CONFIG, {5'h00, r[0], 2'h1});
         half(n);
         chk("half", r[0] ? 16'd25 : 16'd50, n[15:0]);
      end
      rd(`ADDR_CONFIG, v);
      chk("cfg_rd", {8'h00, ph, 7'h05}, {8'h00, v});
      foreach (pat[i])
      begin
         wr(`ADDR_ANNUN, pat[i]);
         repeat (4)
         begin
            idle(13);
            chk("annun", {12'h0, ann(pat[i], bph)}, {12'h0, alit});
         end
      end
      foreach (cv[i])
      begin
         wr(`ADDR_CURSOR, cv[i]);
         repeat (3)
         begin
            idle(11);
            chk("cur_lit", {15'h0, ce[i] == 2'h2 ? ~bph : ce[i][0]}, {15'h0, clit});
         end
      end
      $display("test blink done");
      watch(40, tg, hi);
      chk("pump_run", 16'h1, {15'h0, tg > 0});
      wr(`ADDR_CONFIG, 8'h04);
      wait_blank(1'b1, 1100, n);
      chk("drain", 16'h1, {15'h0, n < 1001});
      chk("halted", 16'h0, {15'h0, mclk});
      // pump and filament gating lag the blank by one cycle
      idle(1);
      watch(64, tg, hi);
      chk("sd_out", 16'h1, {tg[7:0], hi[5:0], drv.pump, drv.tube_blank_out});
      rd(`ADDR_CONFIG, v);
      chk("sd_cfg", {8'h00, ph, 7'h04}, {8'h00, v});
      chk("sd_cur", 16'h5F, {8'h00, cursor});
      chk("sd_cfgo", 16'h04, {8'h00, cfgo});
      wr(`ADDR_CURSOR, 8'h22);
      idle(1);
      chk("sd_wr", 16'h22, {8'h00, cursor});
      dtest = 1'b1;
      idle(3);
      chk("dtest", 16'h1, {15'h0, mclk});
      dtest = 1'b0;
      // shutdown again: scan must stop within one mux period
      idle(1010);
      chk("re_halt", 16'h0, {15'h0, mclk});
      leave_sd(8'h05);
      watch(40, tg, hi);
      chk("resume", 16'h1, {15'h0, tg > 0 && hi > 0});
      chk("stale", 16'h0, {15'h0, stale});
      $display("test shutdown done");
      test_done;
   end
endmodule
